// ===== logic/iop_ports.sv
// Input-only analog-shared ports and two bidirectional ports with CPU register access.
// Assumes pins and CPU strobes are synchronous to i_clk; pin wire resolution is external.
`timescale 1ns/100ps
module iop_ports
   import iop_pkg::*;
(
   input  wire logic                   i_clk,
   input  wire logic                   i_nrst,
   input  wire logic [15:0]            i_cpu_addr,
   input  wire logic                   i_cpu_wr,
   input  wire logic                   i_cpu_rd,
   input  wire logic                   i_cpu_window,
   input  wire logic [PW-1:0]          i_cpu_wdata,
   output logic      [PW-1:0]          o_cpu_rdata,
   output logic                        o_cpu_rvalid,
   output logic                        o_cpu_busy,
   output logic                        o_core_clock_output,
   input  wire logic [PW-1:0]          i_analog_port_a,
   input  wire logic [PW-1:0]          i_analog_port_b,
   input  wire logic [NBP-1:0][PW-1:0] i_pin_in,
   output logic      [NBP-1:0][PW-1:0] o_pin_out,
   output logic      [NBP-1:0][PW-1:0] o_pin_oe,
   input  wire logic [NBP-1:0][PW-1:0] i_peripheral_drive_direction,
   input  wire logic [NBP-1:0][PW-1:0] i_peripheral_drive_value
);

   // =========================================================
   // Control registers
   logic [NBP-1:0][PW-1:0] pin_function_select_q, pin_function_select_d;
   logic [NBP-1:0][PW-1:0] pin_drive_direction_q, pin_drive_direction_d;
   logic [NBP-1:0][PW-1:0] pin_output_value_q, pin_output_value_d;
   logic [NBP-1:0]         port_ok;

   // Window gate per port; bus-control port answers only to full addressing
   always_comb begin
      for (int p = 0; p < NBP; p++) begin
         port_ok[p] = WINDOWABLE[p] | ~i_cpu_window;              // R8 R9
      end
   end

   // Writes land on the next edge; writes beat a read in the same cycle
   always_comb begin
      pin_function_select_d = pin_function_select_q;
      pin_drive_direction_d = pin_drive_direction_q;
      pin_output_value_d    = pin_output_value_q;
      for (int p = 0; p < NBP; p++) begin
         if (i_cpu_wr && port_ok[p]) begin
            if (i_cpu_addr == ADDR_MODE[p]) pin_function_select_d[p] = i_cpu_wdata;  // R6
            if (i_cpu_addr == ADDR_DIR[p])  pin_drive_direction_d[p] = i_cpu_wdata;  // R6
            if (i_cpu_addr == ADDR_OUT[p])  pin_output_value_d[p]    = i_cpu_wdata;  // R6 R12
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         pin_function_select_q <= {NBP{RST_MODE}};
         pin_drive_direction_q <= {NBP{RST_DIR}};
         pin_output_value_q    <= {NBP{RST_OUT}};
      end else begin
         pin_function_select_q <= pin_function_select_d;
         pin_drive_direction_q <= pin_drive_direction_d;
         pin_output_value_q    <= pin_output_value_d;
      end
   end

   // =========================================================
   // Pin drivers
   logic [NBP-1:0][PW-1:0] pin_out_d, pin_oe_d;

   // Built from next register values so a write shows on the pin with the register
   generate
      for (genvar p = 0; p < NBP; p++) begin : g_port
         for (genvar b = 0; b < PW; b++) begin : g_bit
            logic use_std, eff_dir, eff_val;
            assign use_std = (pin_function_select_d[p][b] == MODE_STD);       // R11
            assign eff_dir = use_std ? pin_drive_direction_d[p][b]
                                     : i_peripheral_drive_direction[p][b];    // R13
            assign eff_val = use_std ? pin_output_value_d[p][b]
                                     : i_peripheral_drive_value[p][b];        // R12 R13
            // Push-pull drives both levels; open-drain only pulls low
            assign pin_oe_d[p][b]  = (eff_dir == DIR_PUSH) | ~eff_val;        // R10 R14
            assign pin_out_d[p][b] = (eff_dir == DIR_PUSH) & eff_val;         // R10 R14
         end
      end
   endgenerate

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         o_pin_out <= '0;
         o_pin_oe  <= '0;
      end else begin
         o_pin_out <= pin_out_d;
         o_pin_oe  <= pin_oe_d;
      end
   end

   // =========================================================
   // Phase generator and read sequencer
   iop_rd_t       rd_state_q, rd_state_d;
   logic          phase_q, phase_d;
   logic [15:0]   rd_addr_q, rd_addr_d;
   logic          rd_win_q, rd_win_d;
   logic [PW-1:0] rd_hold_q, rd_hold_d;
   logic [PW-1:0] analog_port_a_level_q, analog_port_a_level_d;
   logic [PW-1:0] analog_port_b_level_q, analog_port_b_level_d;
   logic [PW-1:0] o_cpu_rdata_d;
   logic          o_cpu_rvalid_d;
   logic          o_cpu_busy_d;
   logic          sample_now;

   // Level registers clock only during a read of their own port, which keeps the
   // digital path quiet while the converter shares the same pins
   always_comb begin
      phase_d               = ~phase_q;
      rd_state_d            = rd_state_q;
      rd_addr_d             = rd_addr_q;
      rd_win_d              = rd_win_q;
      rd_hold_d             = rd_hold_q;
      analog_port_a_level_d = analog_port_a_level_q;
      analog_port_b_level_d = analog_port_b_level_q;
      o_cpu_rdata_d         = o_cpu_rdata;
      o_cpu_rvalid_d        = 1'b0;
      sample_now            = (rd_state_q == RD_ALIGN) && (phase_q == PH1);  // R4
      unique case (rd_state_q)
         RD_IDLE: begin
            if (i_cpu_rd && !i_cpu_wr) begin
               rd_addr_d  = i_cpu_addr;
               rd_win_d   = i_cpu_window;
               rd_state_d = RD_ALIGN;
            end
         end
         RD_ALIGN: begin
            if (sample_now) begin
               rd_hold_d = ZERO_BYTE;
               // Pin may move in the window; either level is a valid capture
               if (rd_addr_q == ADDR_LEVEL_A) begin
                  analog_port_a_level_d = i_analog_port_a;                    // R1 R3 R5
                  rd_hold_d             = i_analog_port_a;
               end
               if (rd_addr_q == ADDR_LEVEL_B) begin
                  analog_port_b_level_d = i_analog_port_b;                    // R1 R3 R5
                  rd_hold_d             = i_analog_port_b;
               end
               for (int p = 0; p < NBP; p++) begin
                  if (WINDOWABLE[p] || !rd_win_q) begin
                     if (rd_addr_q == ADDR_MODE[p]) rd_hold_d = pin_function_select_q[p];
                     if (rd_addr_q == ADDR_DIR[p])  rd_hold_d = pin_drive_direction_q[p];
                     if (rd_addr_q == ADDR_OUT[p])  rd_hold_d = pin_output_value_q[p];
                     if (rd_addr_q == ADDR_PIN[p])  rd_hold_d = i_pin_in[p];  // R7
                  end
               end
               rd_state_d = RD_HOLD;
            end
         end
         RD_HOLD: begin
            // Level reads leave through their own latch, never straight from the pins
            if (rd_addr_q == ADDR_LEVEL_A) rd_hold_d = analog_port_a_level_q;    // R3
            if (rd_addr_q == ADDR_LEVEL_B) rd_hold_d = analog_port_b_level_q;    // R3
            rd_state_d = RD_DRIVE;
         end
         RD_DRIVE: begin
            // One state time after the sample, the buffer goes onto the bus
            o_cpu_rdata_d  = rd_hold_q;                                       // R4
            o_cpu_rvalid_d = 1'b1;
            rd_state_d     = RD_IDLE;
         end
      endcase
      o_cpu_busy_d = (rd_state_d != RD_IDLE);
   end

   always_ff @(posedge i_clk) begin
      if (!i_nrst) begin
         rd_state_q            <= RD_IDLE;
         phase_q               <= PH1;
         rd_addr_q             <= '0;
         rd_win_q              <= 1'b0;
         rd_hold_q             <= ZERO_BYTE;
         analog_port_a_level_q <= RST_LEVEL;
         analog_port_b_level_q <= RST_LEVEL;
         o_cpu_rdata           <= ZERO_BYTE;
         o_cpu_rvalid          <= 1'b0;
         o_cpu_busy            <= 1'b0;
         o_core_clock_output   <= PH1;
      end else begin
         rd_state_q            <= rd_state_d;
         phase_q               <= phase_d;
         rd_addr_q             <= rd_addr_d;
         rd_win_q              <= rd_win_d;
         rd_hold_q             <= rd_hold_d;
         analog_port_a_level_q <= analog_port_a_level_d;
         analog_port_b_level_q <= analog_port_b_level_d;
         o_cpu_rdata           <= o_cpu_rdata_d;
         o_cpu_rvalid          <= o_cpu_rvalid_d;
         o_cpu_busy            <= o_cpu_busy_d;
         o_core_clock_output   <= phase_d;
      end
   end

   // =========================================================
   // Assertions
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);

   a_read_latency: assert property (                                  // R4
      (rd_state_q == RD_IDLE && i_cpu_rd && !i_cpu_wr) |-> ##[4:5] o_cpu_rvalid)
      else $error("read answer not in four to five cycles");

   a_level_only_read: assert property (                               // R3
      !sample_now |=> $stable(analog_port_a_level_q) && $stable(analog_port_b_level_q))
      else $error("level register clocked outside a read sample");

   a_sample_low_phase: assert property (                              // R4
      $changed(analog_port_a_level_q) |-> $past(phase_q) == PH1 && o_core_clock_output != PH1)
      else $error("level sampled outside phase one");

   a_push_pull_drive: assert property (                               // R10
      (pin_function_select_q[0][0] == MODE_STD && pin_drive_direction_q[0][0] == DIR_PUSH)
      |-> o_pin_oe[0][0] && o_pin_out[0][0] == pin_output_value_q[0][0])
      else $error("push-pull pin not driving its value");

   a_open_drain_float: assert property (                              // R14
      (pin_function_select_q[0][1] == MODE_STD && pin_drive_direction_q[0][1] != DIR_PUSH
       && pin_output_value_q[0][1]) |-> !o_pin_oe[0][1])
      else $error("open-drain high not released");

   a_open_drain_low: assert property (                                // R14
      (pin_function_select_q[1][2] == MODE_STD && !pin_output_value_q[1][2])
      |-> o_pin_oe[1][2] && !o_pin_out[1][2])
      else $error("output value zero not driven low");

   a_peripheral_owns: assert property (                               // R12 R13
      (pin_function_select_q[0][3] != MODE_STD
       && $past(i_peripheral_drive_direction[0][3]) == DIR_PUSH)
      |-> o_pin_oe[0][3] && o_pin_out[0][3] == $past(i_peripheral_drive_value[0][3]))
      else $error("peripheral not driving its pin");

   a_window_refused: assert property (                                // R9
      (i_cpu_wr && i_cpu_window && i_cpu_addr == ADDR_OUT[1]) |=> $stable(pin_output_value_q[1]))
      else $error("bus-control port written through the window");

   a_window_standard: assert property (                               // R8 R6
      (i_cpu_wr && i_cpu_addr == ADDR_MODE[0]) |=> pin_function_select_q[0] == $past(i_cpu_wdata))
      else $error("standard port mode write lost");

   c_analog_read:  cover property (sample_now && rd_addr_q == ADDR_LEVEL_B ##3 o_cpu_rvalid);
   c_window_block: cover property (i_cpu_wr && i_cpu_window && i_cpu_addr == ADDR_DIR[1]);
   c_periph_mode:  cover property (pin_function_select_q[0] != RST_MODE && o_pin_oe[0] != '0);

endmodule

// ===== logic/iop_pkg.sv
// Constants, addresses and types for the input-only and bidirectional port block.
// Assumes a single core clock; the CPU register port and the pins are synchronous to it.
//
// Notes on behaviour
// R1: Analog-capable pins also read as digital inputs
// R2: Software avoids port reads during analog conversions
// R3: Input-only level register loads only on reads
// R4: Sample one state time before driving bus
// R5: Changing pin may capture old or new
// R6: Mode, direction, output value registers read/write
// R7: Read-only pin level status per port
// R8: Standard port registers byte wide, windowable
// R9: Bus-control port registers refuse windowed access
// R10: Direction 0 push-pull, 1 input/open-drain
// R11: Mode 0 standard I/O, 1 peripheral
// R12: Output value held while peripheral owns pin
// R13: Peripheral direction and value drive pin
// R14: Open-drain: value 1 floats, 0 drives low
package iop_pkg;

   // =========================================================
   // Sizes
   localparam int NBP = 2;                          // Bidirectional ports
   localparam int PW  = 8;                          // Pins per port

   // =========================================================
   // Addresses (index 0: standard port, index 1: bus-control port)
   localparam logic [15:0]          ADDR_LEVEL_A = 16'h1fa8;
   localparam logic [15:0]          ADDR_LEVEL_B = 16'h1fa9;
   localparam logic [NBP-1:0][15:0] ADDR_MODE    = {16'h1ff1, 16'h1fd0};
   localparam logic [NBP-1:0][15:0] ADDR_DIR     = {16'h1ff3, 16'h1fd2};
   localparam logic [NBP-1:0][15:0] ADDR_OUT     = {16'h1ff5, 16'h1fd4};
   localparam logic [NBP-1:0][15:0] ADDR_PIN     = {16'h1ff7, 16'h1fd6};
   localparam logic [NBP-1:0]       WINDOWABLE   = 2'h1;

   // =========================================================
   // Reset values and encodings
   localparam logic [PW-1:0] RST_MODE  = 8'h00;
   localparam logic [PW-1:0] RST_DIR   = 8'hff;
   localparam logic [PW-1:0] RST_OUT   = 8'hff;
   localparam logic [PW-1:0] RST_LEVEL = 8'h00;
   localparam logic [PW-1:0] ZERO_BYTE = 8'h00;
   localparam logic          PH1       = 1'h0;      // Core clock output low
   localparam logic          DIR_PUSH  = 1'h0;
   localparam logic          MODE_STD  = 1'h0;

   // =========================================================
   // Read sequencer states
   typedef enum logic [1:0] {RD_IDLE, RD_ALIGN, RD_HOLD, RD_DRIVE} iop_rd_t;

endpackage

// ===== verif/iop_pin_model.sv
// Pin-side partner: resolves the bidirectional port wires seen by the block.
// Assumes the bench supplies the level that pull-ups or outside parts put on undriven pins.
`timescale 1ns/100ps
module iop_pin_model
   import iop_pkg::*;
(
   input  wire logic [NBP-1:0][PW-1:0] i_pin_out,
   input  wire logic [NBP-1:0][PW-1:0] i_pin_oe,
   input  wire logic [NBP-1:0][PW-1:0] i_ext_level,
   output logic      [NBP-1:0][PW-1:0] o_pin_level
);
   // =========================================================
   // Wire resolution
   // Enabled driver wins; a released pin takes the outside level, never the last value
   always_comb begin
      for (int p = 0; p < NBP; p++) begin
         o_pin_level[p] = (i_pin_oe[p] & i_pin_out[p]) | (~i_pin_oe[p] & i_ext_level[p]);
      end
   end
endmodule

// ===== verif/input_and_bidirectional_ports_tb_top.sv
// Self-checking bench for the port block: register access, pin drive and level reads.
// Assumes iop_pkg, iop_ports and iop_pin_model; peripheral signals come from the bench.
`timescale 1ns/100ps
module input_and_bidirectional_ports_tb_top;
   import iop_pkg::*;
   logic                   i_clk, i_nrst, i_cpu_wr, i_cpu_rd, i_cpu_window, o_cpu_rvalid;
   logic                   o_cpu_busy, core_ck, ck_last, nrst_seen;
   logic [15:0]            i_cpu_addr;
   logic [PW-1:0]          i_cpu_wdata, o_cpu_rdata, an_a, an_b, e_oe, e_out;
   logic [NBP-1:0][PW-1:0] pin_lvl, o_pin_out, o_pin_oe, pdir, pval, ext;
   logic [PW-1:0]          m_mode [NBP];
   logic [PW-1:0]          m_dir  [NBP];
   logic [PW-1:0]          m_out  [NBP];
   logic [PW-1:0]          exp_q  [$];
   int                     n_fail, n_tests;

   // =========================================================
   // Design and pin partner
   iop_ports dut (.i_clk(i_clk), .i_nrst(i_nrst), .i_cpu_addr(i_cpu_addr), .i_cpu_wr(i_cpu_wr),
      .i_cpu_rd(i_cpu_rd), .i_cpu_window(i_cpu_window), .i_cpu_wdata(i_cpu_wdata),
      .o_cpu_rdata(o_cpu_rdata), .o_cpu_rvalid(o_cpu_rvalid), .o_cpu_busy(o_cpu_busy),
      .o_core_clock_output(core_ck), .i_analog_port_a(an_a), .i_analog_port_b(an_b),
      .i_pin_in(pin_lvl), .o_pin_out(o_pin_out), .o_pin_oe(o_pin_oe),
      .i_peripheral_drive_direction(pdir), .i_peripheral_drive_value(pval));
   iop_pin_model pins_m (.i_pin_out(o_pin_out), .i_pin_oe(o_pin_oe), .i_ext_level(ext),
      .o_pin_level(pin_lvl));

   // 40 MHz core clock
   initial begin
      i_clk = 1'h0;
      forever #12.5 i_clk = ~i_clk;
   end

   // =========================================================
   // Tasks
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   task automatic chk(string what, logic [PW-1:0] e, logic [PW-1:0] got);
      n_tests++;
      if (got !== e) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", what, e, got);
      end
   endtask

   task automatic chk_bit(string what, logic e, logic got);
      n_tests++;
      if (got !== e) begin
         n_fail++;
         $display("wrong value %s expected %b seen %b", what, e, got);
      end
   endtask

   task automatic wr(logic [15:0] a, logic [PW-1:0] d, logic win);
      @(negedge i_clk);
      i_cpu_addr = a;
      i_cpu_wdata = d;
      i_cpu_window = win;
      i_cpu_wr = 1'h1;
      @(negedge i_clk);
      i_cpu_wr = 1'h0;
   endtask

   // Expectation queued before the request; the monitor pops it on the answer
   task automatic rd(logic [15:0] a, logic win, logic [PW-1:0] e);
      int k;
      exp_q.push_back(e);
      @(negedge i_clk);
      i_cpu_addr = a;
      i_cpu_window = win;
      i_cpu_rd = 1'h1;
      @(negedge i_clk);
      i_cpu_rd = 1'h0;
      chk_bit("busy", 1'h1, o_cpu_busy);
      k = 0;
      while (o_cpu_rvalid !== 1'h1 && k < 12) begin
         @(negedge i_clk);
         k++;
      end
      if (k == 12) begin
         n_fail++;
         summarize();
      end
   endtask

   task automatic set(int p, int r, logic [PW-1:0] d);
      wr((r == 0) ? ADDR_MODE[p] : (r == 1) ? ADDR_DIR[p] : ADDR_OUT[p], d, 1'h0);
      if (r == 0) m_mode[p] = d;
      else if (r == 1) m_dir[p] = d;
      else m_out[p] = d;
   endtask

   task automatic pins(int p);
      logic [PW-1:0] d, v;
      d = (m_mode[p] & pdir[p]) | (~m_mode[p] & m_dir[p]);
      v = (m_mode[p] & pval[p]) | (~m_mode[p] & m_out[p]);
      e_oe = ~d | ~v;
      e_out = ~d & v;
      chk("pin enable", e_oe, o_pin_oe[p]);
      chk("pin drive", e_out, o_pin_out[p]);
   endtask

   // Read monitor: oldest note against each answer; core clock toggles every cycle
   always @(negedge i_clk) begin
      if (nrst_seen === 1'h1) chk_bit("core clock", ~ck_last, core_ck);
      ck_last = core_ck;
      nrst_seen = i_nrst;
      if (o_cpu_rvalid === 1'h1) begin
         chk_bit("busy at answer", 1'h0, o_cpu_busy);
         if (exp_q.size() == 0) chk("unrequested answer", 8'h00, 8'hff);
         else chk("read data", exp_q.pop_front(), o_cpu_rdata);
      end
   end

   // =========================================================
   // Main sequence
   initial begin
      {i_nrst, i_cpu_wr, i_cpu_rd, i_cpu_window} = 4'h0;
      {i_cpu_addr, i_cpu_wdata, an_a, an_b} = 40'h0;
      {pdir, pval} = 32'h0;
      ext = 16'hffff;
      n_fail = 0;
      n_tests = 0;
      void'($urandom(12783));
      for (int p = 0; p < NBP; p++) begin
         m_mode[p] = RST_MODE;
         m_dir[p] = RST_DIR;
         m_out[p] = RST_OUT;
      end
      repeat (6) @(negedge i_clk);
      i_nrst = 1'h1;
      // Reset values and released pins
      for (int p = 0; p < NBP; p++) begin
         pins(p);
         rd(ADDR_MODE[p], 1'h0, RST_MODE);
         rd(ADDR_DIR[p], 1'h0, RST_DIR);
         rd(ADDR_OUT[p], 1'h0, RST_OUT);
      end
      // Random mixed modes, successive writes one idle cycle apart, pin level status
      for (int i = 0; i < 8; i++) begin
         for (int p = 0; p < NBP; p++) begin
            ext[p] = PW'($urandom);
            pdir[p] = PW'($urandom);
            pval[p] = PW'($urandom);
            set(p, 0, PW'($urandom));
            set(p, 1, PW'($urandom));
            set(p, 2, PW'($urandom));
            pins(p);
            rd(ADDR_PIN[p], 1'h0, (e_oe & e_out) | (~e_oe & ext[p]));
            rd(ADDR_DIR[p], 1'h0, m_dir[p]);
         end
      end
      // Output value written while the peripheral owns the pins
      for (int p = 0; p < NBP; p++) begin
         set(p, 0, 8'hff);
         set(p, 2, ~m_out[p]);
         pins(p);
         rd(ADDR_OUT[p], 1'h0, m_out[p]);
         set(p, 0, 8'h00);
         pins(p);
      end
      // Window mapping: bus-control port refused, standard port accepted
      wr(ADDR_OUT[1], 8'h5a, 1'h1);
      rd(ADDR_OUT[1], 1'h0, m_out[1]);
      rd(ADDR_OUT[1], 1'h1, 8'h00);
      set(0, 2, 8'h3c);
      wr(ADDR_OUT[0], 8'ha5, 1'h1);
      m_out[0] = 8'ha5;
      rd(ADDR_OUT[0], 1'h1, 8'ha5);
      pins(0);
      pins(1);
      rd(16'h1fa7, 1'h0, 8'h00);
      // Input-only levels; no converter runs, so reads are harmless
      for (int i = 0; i < 4; i++) begin
         an_a = PW'($urandom);
         an_b = PW'($urandom);
         rd(ADDR_LEVEL_A, 1'h0, an_a);
         rd(ADDR_LEVEL_B, 1'h0, an_b);
      end
      repeat (4) @(negedge i_clk);
      summarize();
   end
endmodule
